// ### logic/pif_top.sv
// peripheral interrupt enable and request flag block, wishbone slave
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module pif_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // peripheral event pulses, flag 1 layout
  input wire logic [7:0] evt1_i,
  // sources for flag registers 2 and 3, kept outside this block
  input wire logic [7:0] flags2_i,
  input wire logic [7:0] flags3_i,
  // toward the core
  output logic periph_req_o,
  output logic irq_take_o,
  output logic [15:0] vector_o,
  output logic global_gate_o,
  // block interrupt
  output logic irq_o
);
  import pif_pkg::*;

  // enable registers
  logic [7:0] periph_irq_enable_1;
  logic [7:0] periph_irq_enable_2;
  logic [7:0] periph_irq_enable_3;
  // flag register 1
  logic [7:0] periph_irq_flags_1;
  // core control: global and peripheral gate bits
  logic global_irq_gate;
  logic peripheral_irq_gate;
  // sticky event status and mask
  logic [PIF_EVT_N-1:0] evt_status;
  logic [PIF_EVT_N-1:0] evt_mask;
  // bus decode helpers
  logic req;
  logic wr;
  logic wr_b0;
  logic sel_en1;
  logic sel_en2;
  logic sel_en3;
  logic sel_flg1;
  logic sel_core;
  logic sel_st;
  logic sel_msk;
  logic [7:0] next_rdata;
  logic req_d;
  logic [PIF_EVT_N-1:0] evt_set;

  // a new request is taken only when ack is low, single-cycle answer
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  // all registers fit in eight bits, carried on lane 0
  assign wr_b0 = wr & sel_i[0];
  assign sel_en1 = (adr_i == {1'b0, PIF_OFS_EN1});
  assign sel_en2 = (adr_i == {1'b0, PIF_OFS_EN2});
  assign sel_en3 = (adr_i == {1'b0, PIF_OFS_EN3});
  assign sel_flg1 = (adr_i == {1'b0, PIF_OFS_FLG1});
  assign sel_core = (adr_i == PIF_OFS_CORE_W);
  assign sel_st = (adr_i == PIF_OFS_ST);
  assign sel_msk = (adr_i == PIF_OFS_MSK);

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // enable register writes
  // full enable 1 byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_irq_enable_1 <= PIF_RST_BYTE;
      periph_irq_enable_2 <= PIF_RST_BYTE;
      periph_irq_enable_3 <= PIF_RST_BYTE;
    end else if (wr_b0) begin
      if (sel_en1) begin
        periph_irq_enable_1 <= dat_i[7:0] & PIF_MASK_EN1;
      end
      if (sel_en2) begin
        periph_irq_enable_2 <= dat_i[7:0] & PIF_MASK_EN2;
      end
      if (sel_en3) begin
        periph_irq_enable_3 <= dat_i[7:0] & PIF_MASK_EN3;
      end
    end
  end

  // flag register 1: hardware set, masked software write
  // same layout as enable 1
  pif_flags u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(evt1_i),
    .wr_i(wr_b0 & sel_flg1),
    .wdata_i(dat_i[7:0]),
    .wmask_i(PIF_WMASK_FLG1),
    .flags_o(periph_irq_flags_1)
  );

  // or of flag and enable across all three groups
  // groups 2 and 3 take their flags from outside this block
  assign periph_req_o = |(periph_irq_flags_1 & periph_irq_enable_1)
                      | |(flags2_i & periph_irq_enable_2)
                      | |(flags3_i & periph_irq_enable_3);

  // core control word; taking an interrupt drops the global gate
  // hardware clear on take beats a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_gate <= 1'b0;
      peripheral_irq_gate <= 1'b0;
    end else begin
      if (irq_take_o) begin
        global_irq_gate <= 1'b0;
      end else if (wr_b0 && sel_core) begin
        global_irq_gate <= dat_i[PIF_BIT_GLOBAL];
      end
      if (wr_b0 && sel_core) begin
        peripheral_irq_gate <= dat_i[PIF_BIT_PERIPH];
      end
    end
  end
  assign global_gate_o = global_irq_gate;

  // global gate blocks the take and the vector load when clear; periph_req_o and irq_o are not gated
  pif_core_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .periph_req_i(periph_req_o),
    .global_gate_i(global_irq_gate),
    .periph_gate_i(peripheral_irq_gate),
    .irq_take_o(irq_take_o),
    .vector_o(vector_o)
  );

  // event sources: rising request and a taken interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_d <= 1'b0;
    end else begin
      req_d <= periph_req_o;
    end
  end
  assign evt_set = {irq_take_o, periph_req_o & ~req_d};

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status <= PIF_RST_EVT;
    end else begin
      for (int i = 0; i < PIF_EVT_N; i++) begin
        if (evt_set[i]) begin
          evt_status[i] <= 1'b1;
        end else if (wr_b0 && sel_st && dat_i[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask <= PIF_RST_EVT;
    end else if (wr_b0 && sel_msk) begin
      evt_mask <= dat_i[PIF_EVT_N-1:0];
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq_o = |(evt_status & evt_mask);

  // read mux; unmapped addresses read zero and still ack
  // flag bits read one while pending
  always_comb begin
    next_rdata = 8'h00;
    if (sel_en1) begin
      next_rdata = periph_irq_enable_1;
    end else if (sel_en2) begin
      next_rdata = periph_irq_enable_2;
    end else if (sel_en3) begin
      next_rdata = periph_irq_enable_3;
    end else if (sel_flg1) begin
      next_rdata = periph_irq_flags_1;
    end else if (sel_core) begin
      next_rdata = {global_irq_gate, peripheral_irq_gate, 6'h00};
    end else if (sel_st) begin
      next_rdata = {6'h00, evt_status};
    end else if (sel_msk) begin
      next_rdata = {6'h00, evt_mask};
    end
  end

  // read data registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (req && !we_i) begin
      dat_o <= {24'h000000, next_rdata};
    end
  end
endmodule

// ### logic/pif_pkg.sv
// constants and offsets for the peripheral interrupt gating block
package pif_pkg;
  // register word offsets on the wishbone bus (byte addresses)
  localparam logic [3:0] PIF_OFS_EN1 = 4'h0;
  localparam logic [3:0] PIF_OFS_EN2 = 4'h4;
  localparam logic [3:0] PIF_OFS_EN3 = 4'h8;
  localparam logic [3:0] PIF_OFS_FLG1 = 4'hc;
  // core control word: global and peripheral gates
  localparam logic [3:0] PIF_OFS_CORE = 4'h0;
  localparam logic [4:0] PIF_OFS_CORE_W = 5'h10;
  localparam logic [4:0] PIF_OFS_ST = 5'h14;
  localparam logic [4:0] PIF_OFS_MSK = 5'h18;
  // bit positions in the core control word
  localparam int PIF_BIT_GLOBAL = 7;
  localparam int PIF_BIT_PERIPH = 6;
  // implemented-bit masks; unimplemented positions read zero
  localparam logic [7:0] PIF_MASK_EN1 = 8'hff;
  localparam logic [7:0] PIF_MASK_EN2 = 8'hef;
  localparam logic [7:0] PIF_MASK_EN3 = 8'h7f;
  localparam logic [7:0] PIF_MASK_CORE = 8'hc0;
  // flag bits software may write; serial rx/tx are read-only
  localparam logic [7:0] PIF_WMASK_FLG1 = 8'hcf;
  // values after every reset
  localparam logic [7:0] PIF_RST_BYTE = 8'h00;
  localparam logic [1:0] PIF_RST_EVT = 2'h0;
  // vector loaded by the core on taking an interrupt
  localparam logic [15:0] PIF_VECTOR = 16'h0004;
  // sticky event bits: 0 request rose, 1 interrupt taken
  localparam int PIF_EVT_N = 2;
endpackage

// ### logic/pif_flags.sv
// request flag register: hardware set beats software clear
`timescale 1ns/100ps
module pif_flags (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // hardware event pulses
  input wire logic [7:0] set_i,
  // software write
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] wmask_i,
  // stored flags
  output logic [7:0] flags_o
);
  import pif_pkg::*;

  // one flop per flag, same shape for every source
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      // private flop per bit, so no process shares a written variable
      logic flag;
      // set wins over a write of zero in the same cycle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag <= 1'b0;
        end else if (set_i[g]) begin
          flag <= 1'b1;
        end else if (wr_i && wmask_i[g]) begin
          flag <= wdata_i[g];
        end
      end
      // bit of the output vector straight from its flop
      assign flags_o[g] = flag;
    end
  endgenerate
endmodule

// ### logic/pif_core_gate.sv
// core-side gating: global and peripheral gates, vector on take
`timescale 1ns/100ps
module pif_core_gate (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // gate control
  input wire logic periph_req_i,
  input wire logic global_gate_i,
  input wire logic periph_gate_i,
  // outputs toward the core
  output logic irq_take_o,
  output logic [15:0] vector_o
);
  import pif_pkg::*;

  // take is combinational, the vector is held in a flop
  assign irq_take_o = periph_req_i & periph_gate_i & global_gate_i;

  // latch the vector address when an interrupt is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_o <= 16'h0000;
    end else if (irq_take_o) begin
      vector_o <= PIF_VECTOR;
    end
  end
endmodule

// ### tb/pif_src_model.sv
// event source model: flag 1 pulses and group 2/3 flag levels
`timescale 1ns/100ps
module pif_src_model (
  // clock
  input wire logic clk_i,
  // request from the bench
  input wire logic [23:0] cmd_i,
  // toward the block
  output logic [7:0] evt1_o,
  output logic [7:0] flags2_o,
  output logic [7:0] flags3_o
);
  // pulses in flag 1 layout, levels held
  always_ff @(posedge clk_i) begin
    evt1_o <= cmd_i[7:0];
    flags2_o <= cmd_i[15:8];
    flags3_o <= cmd_i[23:16];
  end
endmodule

// ### tb/pif_top_checker.sv
// port assertions of the interrupt gating block
`timescale 1ns/100ps
module pif_top_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched outputs
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic periph_req_o,
  input wire logic irq_take_o,
  input wire logic [15:0] vector_o,
  input wire logic global_gate_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_take_needs_req: assert property (irq_take_o |-> periph_req_o)
    else $error("take without request");
  a_take_needs_gate: assert property (irq_take_o |-> global_gate_o)
    else $error("take with global gate clear");
  a_take_clears_gate: assert property (irq_take_o |=> !global_gate_o)
    else $error("global gate kept after take");
  a_vector_on_take: assert property (irq_take_o |=> vector_o == 16'h0004)
    else $error("vector not loaded");
  a_vector_held: assert property ($changed(vector_o) |-> $past(irq_take_o))
    else $error("vector moved without take");
  a_gate_cause: assert property ($changed(global_gate_o) |-> ack_o || $past(irq_take_o))
    else $error("global gate moved on its own");
  a_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // checked during reset too, so no disable here
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=> !global_gate_o &&
    vector_o == 16'h0 && !periph_req_o && !irq_o) else $error("reset left state");
  c_take: cover property (irq_take_o);
  c_irq: cover property (irq_o);
  c_read: cover property (ack_o && dat_o[7:0] != 8'h0);
endmodule
bind pif_top pif_top_checker u_chk (.clk_i, .rst_i, .dat_o, .ack_o, .periph_req_o,
  .irq_take_o, .vector_o, .global_gate_o, .irq_o);

// ### tb/tb_pif_top.sv
// self-checking bench for the interrupt gating block
`timescale 1ns/100ps
module tb_pif_top;
  import pif_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [4:0] adr_i = 5'h0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rs = 32'h3576baec, e;
  logic ack_o, periph_req_o, irq_take_o, global_gate_o, irq_o;
  logic [15:0] vector_o;
  logic [7:0] evt1_i, flags2_i, flags3_i, rd, acc;
  logic [23:0] cmd = 24'h0;
  int mismatches = 0, compares = 0;
  // clock, 40 ns period
  initial forever #20 clk_i = ~clk_i;
  pif_src_model u_src (.clk_i, .cmd_i(cmd), .evt1_o(evt1_i), .flags2_o(flags2_i),
    .flags3_o(flags3_i));
  pif_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .evt1_i, .flags2_i, .flags3_i, .periph_req_o, .irq_take_o, .vector_o,
    .global_gate_o, .irq_o);
  // xorshift draw
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected request: flag and enable over three groups
  function automatic logic rq(logic [31:0] en, logic [23:0] f);
    return |(f[7:0] & en[7:0]) | |(f[15:8] & en[15:8] & PIF_MASK_EN2)
      | |(f[23:16] & en[23:16] & PIF_MASK_EN3);
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one classic cycle; waits for ack, bounded
  task automatic wb(logic w, logic [4:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = dat_o[7:0];
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // all places, unmapped included, read zero
    for (int a = 0; a < 32; a += 4) begin
      wb(0, a[4:0], 8'h0);
      chk(rd, 8'h0);
    end
    $display("test 1 done");
    // all-ones writes keep implemented bits only
    wb(1, 5'h00, 8'hff);
    wb(1, 5'h04, 8'hff);
    wb(1, 5'h08, 8'hff);
    wb(1, 5'h0c, 8'hff);
    wb(0, 5'h00, 8'h0);
    chk(rd, 8'hff);
    wb(0, 5'h04, 8'h0);
    chk(rd, 8'hef);
    wb(0, 5'h08, 8'h0);
    chk(rd, 8'h7f);
    wb(0, 5'h0c, 8'h0);
    chk(rd, 8'hcf);
    wb(1, 5'h10, 8'h40);
    chk(irq_take_o, 1'h0);
    wb(1, 5'h10, 8'h80);
    chk(irq_take_o, 1'h0);
    wb(1, 5'h10, 8'hff);
    wb(0, 5'h10, 8'h0);
    chk(rd, 8'h40);
    chk(vector_o, 16'h0004);
    $display("test 2 done");
    // status sticky, masked, cleared by ones
    wb(0, 5'h14, 8'h0);
    chk(rd, 8'h03);
    chk(irq_o, 1'h0);
    wb(1, 5'h18, 8'h03);
    chk(irq_o, 1'h1);
    wb(1, 5'h14, 8'h01);
    wb(0, 5'h14, 8'h0);
    chk(rd, 8'h02);
    wb(1, 5'h14, 8'h02);
    chk(irq_o, 1'h0);
    $display("test 3 done");
    wb(1, 5'h10, 8'h0);
    wb(1, 5'h0c, 8'h0);
    acc = 8'h0;
    for (int i = 0; i < 24; i++) begin
      rs = xs(rs);
      e = rs;
      wb(1, 5'h00, e[7:0]);
      wb(1, 5'h04, e[15:8]);
      wb(1, 5'h08, e[23:16]);
      rs = xs(rs);
      @(posedge clk_i);
      cmd <= rs[23:0];
      @(posedge clk_i);
      cmd[7:0] <= 8'h0;
      acc = acc | rs[7:0];
      wb(0, 5'h0c, 8'h0);
      chk(rd, acc);
      chk(periph_req_o, rq(e, {rs[23:8], acc}));
      chk(irq_take_o, 1'h0);
      wb(1, 5'h0c, 8'h0);
      // serial rx/tx flags survive the clear
      acc = acc & 8'h30;
    end
    $display("test 4 done");
    // lane 0 off and unmapped writes are ignored
    sel_i <= 4'h0;
    wb(1, 5'h00, ~e[7:0]);
    sel_i <= 4'h1;
    wb(1, 5'h1c, 8'hff);
    wb(0, 5'h00, 8'h0);
    chk(rd, e[7:0]);
    wb(0, 5'h1c, 8'h0);
    chk(rd, 8'h0);
    // reset in mid-run
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 5'h00, 8'h0);
    chk(rd, 8'h0);
    wb(0, 5'h0c, 8'h0);
    chk(rd, 8'h0);
    $display("test 5 done");
    end_of_test();
  end
endmodule
